// ---- rtl/spi_cmd_params.svh ----
// Constants for the SPI command decode and response block.
`ifndef SPI_CMD_PARAMS_SVH
`define SPI_CMD_PARAMS_SVH

`define FRAME_BITS        32
`define FRAME_LAST_BIT    5'h1f
`define CMD_MSB           31
`define CMD_LSB           28
`define ADDR_MSB          23
`define ADDR_LSB          16
`define WDATA_MSB         15
`define WDATA_LSB         8
`define CMD_ERROR         4'h0
`define CMD_REG_WRITE     4'h8
`define CMD_REG_READ      4'hc
`define STATUS_ERROR      2'h3
`define DETAIL_BAD_CMD    2'h1
`define DETAIL_NO_SOURCE  2'h2
`define DETAIL_LINK_ERROR 2'h3
`define CRC_POLY          8'h2f
`define CRC_SEED          8'hff
`define RESP_RESET        32'h00000000

`endif

// ---- rtl/spi_cmd_pkg.sv ----
// Types shared by the SPI command decode and response block.
package spi_cmd_pkg;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_decode = 2'b01,
        st_fetch  = 2'b11
    } fsm_type;

    typedef struct packed {
        logic [2:0]  channel_source_field;
        logic [11:0] sample_value;
        logic [3:0]  extra_bits;
    } channel_type;

    typedef struct packed {
        logic [30:0] shift;
        logic [4:0]  count;
    } link_in_type;

    typedef struct packed {
        fsm_type     fsm;
        logic [2:0]  frame_sync;
        logic [31:0] command;
        logic [31:0] response;
        logic        reg_write;
        logic        reg_read;
        logic [7:0]  reg_addr;
        logic [7:0]  reg_wdata;
    } core_type;

endpackage : spi_cmd_pkg

// ---- rtl/spi_command_decode_response.sv ----
// SPI command decoder and response frame builder of the pressure sensor.
//
// Summary of operation
// - Command code zero marks only error responses.
// - Odd code is sensor request, selector C[3:1].
// - Serve channel whose source field matches selector.
// - Code 1000 is a register write.
// - Code 1100 is a register read.
// - Reserved codes are never valid requests.
// - Sensor response: command, status, data, detail, CRC.
// - Sensor data: 12-bit sample then extra bits.
// - 32-bit MSB-first mode 0, answer next frame.
// - Link errors replace the register read answer.
`include "spi_cmd_params.svh"

module spi_command_decode_response #(
    parameter int CHANNELS = 2
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_reset,
    input  wire logic                     i_sclk,
    input  wire logic                     i_select_n,
    input  wire logic                     i_mosi,
    output logic                          o_miso,
    output logic                          o_miso_oe_n,
    input  wire spi_cmd_pkg::channel_type i_channel [CHANNELS],
    input  wire logic [1:0]               i_basic_status,
    input  wire logic [1:0]               i_detail_status,
    input  wire logic                     i_spi_error,
    input  wire logic                     i_miso_error,
    input  wire logic                     i_write_locked,
    input  wire logic [15:0]              i_reg_rdata,
    output logic                          o_reg_write,
    output logic                          o_reg_read,
    output logic [7:0]                    o_reg_addr,
    output logic [7:0]                    o_reg_wdata,
    output logic [31:0]                   o_last_command
);

    // Link side, clocked by the host's serial clock; the shift register and bit index are held in reset while deselected.
    spi_cmd_pkg::link_in_type link_in;
    logic [4:0]               out_index;
    logic [31:0]              captured;
    logic                     frame_toggle;

    always_ff @(posedge i_sclk or posedge i_select_n) begin
        if (i_select_n) begin
            link_in <= '0;
        end else begin
            link_in.shift <= {link_in.shift[29:0], i_mosi};
            link_in.count <= link_in.count + 5'h01;
        end
    end

    // The captured word and its toggle must survive deselection, so only the
    // system reset clears them; a frame shorter than 32 bits never toggles.
    always_ff @(posedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            captured     <= `RESP_RESET;
            frame_toggle <= 1'b0;
        end else if (!i_select_n && link_in.count == `FRAME_LAST_BIT) begin
            captured     <= {link_in.shift, i_mosi};
            frame_toggle <= ~frame_toggle;
        end
    end

    always_ff @(negedge i_sclk or posedge i_select_n) begin
        if (i_select_n) begin
            out_index <= `FRAME_LAST_BIT;
        end else begin
            out_index <= out_index - 5'h01;
        end
    end

    spi_cmd_pkg::core_type core;
    spi_cmd_pkg::core_type next_core;

    // The response word is only rewritten a few system cycles after the last
    // rising edge of a frame and then stands for the whole next frame, so the
    // link side reads it as a quasi-static word without a further crossing.
    assign o_miso      = core.response[out_index];
    assign o_miso_oe_n = i_select_n;

    function automatic logic [7:0] crc8(input logic [23:0] data);
        logic [7:0] crc;
        crc = `CRC_SEED;
        for (int i = 23; i >= 0; i--) begin
            if (crc[7] ^ data[i]) begin
                crc = {crc[6:0], 1'b0} ^ `CRC_POLY;
            end else begin
                crc = {crc[6:0], 1'b0};
            end
        end
        return crc;
    endfunction : crc8

    function automatic logic [31:0] frame_out(input logic [23:0] body);
        return {body, crc8(body)};
    endfunction : frame_out

    logic [CHANNELS-1:0] match;
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_match
            assign match[ch] = i_channel[ch].channel_source_field == core.command[31:29];
        end
    endgenerate

    logic [15:0] selected_data;
    always_comb begin
        selected_data = 16'h0000;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (match[i]) begin
                selected_data = {i_channel[i].sample_value, i_channel[i].extra_bits};
            end
        end
    end

    logic [3:0] code;
    logic [3:0] echo;
    logic       link_error;
    assign code       = core.command[`CMD_MSB:`CMD_LSB];
    assign echo       = {code[0], code[3:1]};
    assign link_error = i_spi_error | i_miso_error;

    always_comb begin
        next_core            = core;
        next_core.frame_sync = {core.frame_sync[1:0], frame_toggle};
        next_core.reg_write  = 1'b0;
        next_core.reg_read   = 1'b0;
        unique case (core.fsm)
            spi_cmd_pkg::st_idle: begin
                if (core.frame_sync[2] != core.frame_sync[1]) begin
                    next_core.command = captured;
                    next_core.fsm     = spi_cmd_pkg::st_decode;
                end
            end
            spi_cmd_pkg::st_decode: begin
                next_core.fsm       = spi_cmd_pkg::st_idle;
                next_core.reg_addr  = core.command[`ADDR_MSB:`ADDR_LSB];
                next_core.reg_wdata = core.command[`WDATA_MSB:`WDATA_LSB];
                if (code[0]) begin
                    if (|match) begin
                        next_core.response = frame_out({echo, i_basic_status,
                                                        selected_data, i_detail_status});
                    end else begin
                        next_core.response = frame_out({`CMD_ERROR, `STATUS_ERROR,
                                                        16'h0000, `DETAIL_NO_SOURCE});
                    end
                end else if (code == `CMD_REG_WRITE) begin
                    if (link_error || i_write_locked) begin
                        next_core.response = frame_out({`CMD_ERROR, `STATUS_ERROR,
                                                        16'h0000, `DETAIL_LINK_ERROR});
                    end else begin
                        next_core.reg_write = 1'b1;
                        next_core.response  = frame_out({echo, i_basic_status, 2'h0,
                                                         8'h00, next_core.reg_wdata});
                    end
                end else if (code == `CMD_REG_READ) begin
                    if (link_error) begin
                        next_core.response = frame_out({`CMD_ERROR, `STATUS_ERROR,
                                                        16'h0000, `DETAIL_LINK_ERROR});
                    end else begin
                        next_core.reg_read = 1'b1;
                        next_core.fsm      = spi_cmd_pkg::st_fetch;
                    end
                end else begin
                    next_core.response = frame_out({`CMD_ERROR, `STATUS_ERROR,
                                                    16'h0000, `DETAIL_BAD_CMD});
                end
            end
            spi_cmd_pkg::st_fetch: begin
                next_core.fsm = spi_cmd_pkg::st_idle;
                next_core.response = frame_out({echo, i_basic_status, 2'h0, i_reg_rdata});
            end
            default: begin
                next_core.fsm = spi_cmd_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            core <= '{fsm: spi_cmd_pkg::st_idle, command: `RESP_RESET,
                      response: `RESP_RESET, default: '0};
        end else begin
            core <= next_core;
        end
    end

    assign o_reg_write    = core.reg_write;
    assign o_reg_read     = core.reg_read;
    assign o_reg_addr     = core.reg_addr;
    assign o_reg_wdata    = core.reg_wdata;
    assign o_last_command = core.command;

endmodule : spi_command_decode_response

// ---- test/spi_command_decode_response_properties.sv ----
// Checker for the register strobes and output enable of the SPI command block.
module spi_command_decode_response_properties (
    input wire logic        i_clock,
    input wire logic        i_reset,
    input wire logic        i_select_n,
    input wire logic        i_spi_error,
    input wire logic        i_miso_error,
    input wire logic        i_write_locked,
    input wire logic        o_miso_oe_n,
    input wire logic        o_reg_write,
    input wire logic        o_reg_read,
    input wire logic [7:0]  o_reg_addr,
    input wire logic [7:0]  o_reg_wdata,
    input wire logic [31:0] o_last_command
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    oe_follows_select_a: assert property (o_miso_oe_n == i_select_n)
        else $error("miso enable differs from select");
    write_one_cycle_a: assert property (o_reg_write |=> !o_reg_write [*8])
        else $error("write strobe too long");
    read_one_cycle_a: assert property (o_reg_read |=> !o_reg_read [*8])
        else $error("read strobe too long");
    write_code_match_a: assert property (o_reg_write |-> o_last_command[31:28] == 4'h8
        && o_reg_addr == o_last_command[23:16] && o_reg_wdata == o_last_command[15:8])
        else $error("write strobe without write command");
    read_code_match_a: assert property (o_reg_read |-> o_last_command[31:28] == 4'hc
        && o_reg_addr == o_last_command[23:16]) else $error("read strobe without read command");
    write_refused_a: assert property (o_reg_write |-> !$past(i_spi_error)
        && !$past(i_miso_error) && !$past(i_write_locked)) else $error("write not refused");
    read_refused_a: assert property (o_reg_read |-> !$past(i_spi_error)
        && !$past(i_miso_error)) else $error("read not refused");
    strobe_exclusive_a: assert property (!(o_reg_write && o_reg_read))
        else $error("both strobes at once");
endmodule : spi_command_decode_response_properties

bind spi_command_decode_response spi_command_decode_response_properties i_props (.i_clock,
    .i_reset, .i_select_n, .i_spi_error, .i_miso_error, .i_write_locked, .o_miso_oe_n,
    .o_reg_write, .o_reg_read, .o_reg_addr, .o_reg_wdata, .o_last_command);

// ---- test/spi_command_decode_response_tb.sv ----
// Self-checking bench for the SPI command decoder and response builder.
module spi_command_decode_response_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic sclk, select_n, mosi, miso, miso_oe_n, reg_write, reg_read;
    logic [1:0] basic_status = 2'h1;
    logic [1:0] detail_status = 2'h0;
    logic spi_error = 1'b0;
    logic miso_error = 1'b0;
    logic write_locked = 1'b0;
    logic [15:0] reg_rdata = 16'h0;
    logic [7:0] reg_addr, reg_wdata;
    logic [31:0] last_command, rsp;
    logic [23:0] pend = 24'h0;
    logic [3:0] bad [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he};
    spi_cmd_pkg::channel_type chan [2] = '{{3'h3, 12'habc, 4'h5}, {3'h5, 12'h123, 4'h9}};
    int fails = 0;
    int checks = 0;
    spi_command_decode_response i_spi_command_decode_response (.i_clock, .i_reset,
        .i_sclk(sclk), .i_select_n(select_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe_n(miso_oe_n), .i_channel(chan), .i_basic_status(basic_status),
        .i_detail_status(detail_status), .i_spi_error(spi_error), .i_miso_error(miso_error),
        .i_write_locked(write_locked), .i_reg_rdata(reg_rdata), .o_reg_write(reg_write),
        .o_reg_read(reg_read), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
        .o_last_command(last_command));
    // The released data line is pulled high.
    spi_host_model i_spi_host_model (.o_sclk(sclk), .o_select_n(select_n), .o_mosi(mosi),
        .i_miso(miso_oe_n ? 1'b1 : miso));
    initial begin
        forever #5 i_clock = ~i_clock;
    end
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Each frame returns the reply to the frame before it; CRC byte is not compared.
    task automatic go(input logic [31:0] cmd, input logic [23:0] exp);
        @(posedge i_clock);
        i_spi_host_model.xfer(cmd, rsp);
        check({8'h0, rsp[31:8]}, {8'h0, pend});
        check(last_command, cmd);
        pend = exp;
    endtask : go
    initial begin
        #500us;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clock);
        for (int s = 0; s < 8; s++) begin
            go({s[2:0], 1'b1, 28'h0}, s == 3 ? {4'hb, 2'h1, 12'habc, 4'h5, 2'h0} :
                s == 5 ? {4'hd, 2'h1, 12'h123, 4'h9, 2'h0} : 24'h0c0002);
        end
        foreach (bad[i]) go({bad[i], 28'h0}, 24'h0c0001);
        go(32'h80125a00, 24'h44005a);
        check({16'h0, reg_addr, reg_wdata}, 32'h125a);
        @(posedge i_clock) write_locked <= 1'b1;
        go(32'h80340100, 24'h0c0003);
        @(posedge i_clock) write_locked <= 1'b0;
        reg_rdata <= 16'hbeef;
        go(32'hc0560000, 24'h64beef);
        check({24'h0, reg_addr}, 32'h56);
        @(posedge i_clock) spi_error <= 1'b1;
        go(32'hc0560000, 24'h0c0003);
        @(posedge i_clock) spi_error <= 1'b0;
        miso_error <= 1'b1;
        go(32'hc0560000, 24'h0c0003);
        @(posedge i_clock) miso_error <= 1'b0;
        basic_status <= 2'h3;
        detail_status <= 2'h2;
        go(32'h70000000, {4'hb, 2'h3, 12'habc, 4'h5, 2'h2});
        go(32'h10000000, 24'h0c0002);
        // One more frame fetches the reply to the frame before it.
        go(32'h30000000, 24'h0c0002);
        print_verdict();
    end
endmodule : spi_command_decode_response_tb

// ---- test/spi_host_model.sv ----
// Behavioural SPI host sending 32-bit frames and capturing the reply.
module spi_host_model (
    output logic      o_sclk,
    output logic      o_select_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_mosi = 1'b0;
    end
    // mode 0, MSB first, clock still outside frames.
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        #3.7 o_select_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_mosi = cmd[i];
            #62.5 o_sclk = 1'b1;
            rsp[i] = i_miso;
            #62.5 o_sclk = 1'b0;
        end
        o_mosi = ~o_mosi;
        #62.5 o_select_n = 1'b1;
        // Gap well above eight system cycles so the reply word settles.
        #400;
    endtask : xfer
endmodule : spi_host_model
